// file: design/iad_pkg.sv
// Constants, register map and types of the integer add datapath
package iad_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int IAD_XLEN = 32;
	localparam int IAD_FLEN = 64;
	localparam int IAD_NGPR = 32;
	localparam int IAD_NFPR = 8;
	localparam int IAD_ADDR_W = 12;
	localparam int IAD_RIDX_W = 5;
	localparam int IAD_IMM_W = 16;
	localparam int IAD_OPCD_W = 6;
	localparam int IAD_XO_W = 9;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [11:0] IAD_OFF_INSTR = 12'h000;
	localparam logic [11:0] IAD_OFF_FXEXC = 12'h004;
	localparam logic [11:0] IAD_OFF_CFZ = 12'h008;
	localparam logic [11:0] IAD_OFF_STAT = 12'h00c;
	localparam logic [11:0] IAD_OFF_GPR = 12'h100;
	localparam logic [11:0] IAD_OFF_FPR = 12'h200;
	localparam logic [11:0] IAD_WIN_MASK = 12'hf80;
	localparam int IAD_IDX_LSB = 2;

	// ----------------------------------------
	// Bit positions
	// ----------------------------------------
	localparam int IAD_FX_UWRAP = 0;
	localparam int IAD_FX_SWRAP = 1;
	localparam int IAD_FX_STICKY = 2;
	localparam int IAD_CR_SO = 0;
	localparam int IAD_CR_ZERO = 1;
	localparam int IAD_CR_POS = 2;
	localparam int IAD_CR_NEG = 3;
	localparam int IAD_STAT_OK = 0;
	localparam int IAD_STAT_BAD = 1;

	// ----------------------------------------
	// Instruction fields and encodings
	// ----------------------------------------
	localparam int IAD_OPCD_LSB = 26;
	localparam int IAD_RD_LSB = 21;
	localparam int IAD_RA_LSB = 16;
	localparam int IAD_RB_LSB = 11;
	localparam int IAD_OE_BIT = 10;
	localparam int IAD_XO_LSB = 1;
	localparam int IAD_RC_BIT = 0;
	localparam logic [5:0] IAD_OP_XO = 6'h1f;
	localparam logic [5:0] IAD_OP_ADDIC = 6'h0c;
	localparam logic [5:0] IAD_OP_ADDIC_REC = 6'h0d;
	localparam logic [5:0] IAD_OP_ADDI = 6'h0e;
	localparam logic [5:0] IAD_OP_ADDIS = 6'h0f;
	localparam logic [8:0] IAD_XO_ADD = 9'h10a;
	localparam logic [8:0] IAD_XO_ADDC = 9'h00a;
	localparam logic [8:0] IAD_XO_ADDE = 9'h08a;
	localparam logic [8:0] IAD_XO_ADDME = 9'h0ea;
	localparam logic [8:0] IAD_XO_ADDZE = 9'h0ca;
	localparam logic [31:0] IAD_ALL_ONES = 32'hffff_ffff;

	// ----------------------------------------
	// Bus responses
	// ----------------------------------------
	localparam logic [1:0] IAD_RESP_OKAY = 2'h0;
	localparam logic [1:0] IAD_RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		IAD_NONE, IAD_ADD, IAD_ADDC, IAD_ADDE, IAD_ADDME, IAD_ADDZE,
		IAD_ADDI, IAD_ADDIC, IAD_ADDIC_REC, IAD_ADDIS
	} iad_op_type;
endpackage : iad_pkg

// file: design/iad_adder.sv
// Carry-in adder with carry-out and signed overflow
`timescale 1ns/1ps
module iad_adder (
	// Operands
	input wire logic [iad_pkg::IAD_XLEN-1:0] a_in,
	input wire logic [iad_pkg::IAD_XLEN-1:0] b_in,
	input wire logic carry_in,
	// Result
	output logic [iad_pkg::IAD_XLEN-1:0] sum_out,
	output logic carry_out,
	output logic ovf_out
);
	import iad_pkg::*;

	logic [IAD_XLEN:0] full;

	assign full = {1'b0, a_in} + {1'b0, b_in} + {{IAD_XLEN{1'b0}}, carry_in};
	assign sum_out = full[IAD_XLEN-1:0];
	assign carry_out = full[IAD_XLEN];
	// Same-sign operands giving an opposite-sign result
	assign ovf_out = (a_in[IAD_XLEN-1] == b_in[IAD_XLEN-1]) &&
		(sum_out[IAD_XLEN-1] != a_in[IAD_XLEN-1]);
endmodule : iad_adder

// file: design/iad_add_datapath.sv
// Integer add datapath with its AXI4-Lite register slave
// Functional notes
// - General and special registers are 32 bits wide; addresses are 12 bits wide.
// - Each float register holds 64 bits.
// - Add writes the sum of two registers; carry stays unchanged.
// - Add carrying writes the sum and records carry out in the wrap bit.
// - Add extended adds both registers plus carry and updates carry.
// - Add immediate adds sign-extended immediate; no status bits change.
// - In add immediate and shifted, a zero source field selects constant zero.
// - Add immediate carrying updates carry but leaves condition field zero.
// - Add immediate carrying and record updates carry and condition field zero.
// - Add immediate shifted adds immediate in the upper half; no status change.
// - Add to minus one adds register, carry and all ones; updates carry.
// - Add to zero adds register and carry; updates carry.
// - Record bit set updates negative, positive, zero and sticky condition bits.
// - Overflow enable set updates signed wrap and sticky signed wrap bits.
// - Condition field zero follows the truncated result even on overflow.
`timescale 1ns/1ps
module iad_add_datapath (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	// Write address channel
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [iad_pkg::IAD_ADDR_W-1:0] s_axi_awaddr_in,
	// Write data channel
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [iad_pkg::IAD_XLEN-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// Write response channel
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// Read address channel
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [iad_pkg::IAD_ADDR_W-1:0] s_axi_araddr_in,
	// Read data channel
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [iad_pkg::IAD_XLEN-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out
);
	import iad_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic aw_have;
		logic [IAD_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [IAD_XLEN-1:0] w_data;
		logic [3:0] w_strb;
		logic aw_rdy;
		logic w_rdy;
		logic b_valid;
		logic [1:0] b_resp;
		logic ar_rdy;
		logic r_valid;
		logic [IAD_XLEN-1:0] r_data;
		logic [1:0] r_resp;
		logic [IAD_XLEN-1:0] last_instr;
		logic last_ok;
		logic last_bad;
		logic ca;
		logic ov;
		logic so;
		logic [3:0] cr0;
		logic [IAD_NGPR-1:0][IAD_XLEN-1:0] gpr;
		logic [IAD_NFPR-1:0][IAD_FLEN-1:0] float_register;
	} iad_state_type;

	iad_state_type st_reg;
	iad_state_type st_next;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Returns {hit, word} for a register read at the given address
	function automatic logic [IAD_XLEN:0] reg_word(input iad_state_type s,
			input logic [IAD_ADDR_W-1:0] a);
		logic [IAD_RIDX_W-1:0] i;
		logic [IAD_XLEN-1:0] w;
		logic hit;
		i = a[IAD_IDX_LSB +: IAD_RIDX_W];
		w = '0;
		hit = 1'b1;
		if (a == IAD_OFF_INSTR) begin
			w = s.last_instr;
		end else if (a == IAD_OFF_FXEXC) begin
			w[IAD_FX_UWRAP] = s.ca;
			w[IAD_FX_SWRAP] = s.ov;
			w[IAD_FX_STICKY] = s.so;
		end else if (a == IAD_OFF_CFZ) begin
			w[3:0] = s.cr0;
		end else if (a == IAD_OFF_STAT) begin
			w[IAD_STAT_OK] = s.last_ok;
			w[IAD_STAT_BAD] = s.last_bad;
		end else if ((a & IAD_WIN_MASK) == IAD_OFF_GPR) begin
			w = s.gpr[i];
		end else if ((a & IAD_WIN_MASK) == IAD_OFF_FPR && !i[4]) begin
			w = i[0] ? s.float_register[i[3:1]][IAD_FLEN-1:IAD_XLEN] : s.float_register[i[3:1]][IAD_XLEN-1:0];
		end else begin
			hit = 1'b0;
		end
		reg_word = {hit, w};
	endfunction : reg_word

	function automatic logic [IAD_XLEN-1:0] merge(input logic [IAD_XLEN-1:0] old,
			input logic [IAD_XLEN-1:0] nw, input logic [3:0] strb);
		logic [IAD_XLEN-1:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				r[8*k +: 8] = nw[8*k +: 8];
			end
		end
		merge = r;
	endfunction : merge

	function automatic iad_op_type decode_op(input logic [IAD_XLEN-1:0] ins);
		decode_op = IAD_NONE;
		case (ins[IAD_OPCD_LSB +: IAD_OPCD_W])
			IAD_OP_ADDI: decode_op = IAD_ADDI;
			IAD_OP_ADDIS: decode_op = IAD_ADDIS;
			IAD_OP_ADDIC: decode_op = IAD_ADDIC;
			IAD_OP_ADDIC_REC: decode_op = IAD_ADDIC_REC;
			IAD_OP_XO: begin
				case (ins[IAD_XO_LSB +: IAD_XO_W])
					IAD_XO_ADD: decode_op = IAD_ADD;
					IAD_XO_ADDC: decode_op = IAD_ADDC;
					IAD_XO_ADDE: decode_op = IAD_ADDE;
					IAD_XO_ADDME: decode_op = IAD_ADDME;
					IAD_XO_ADDZE: decode_op = IAD_ADDZE;
					default: decode_op = IAD_NONE;
				endcase
			end
			default: decode_op = IAD_NONE;
		endcase
	endfunction : decode_op

	function automatic logic [IAD_XLEN-1:0] pick_b(input iad_op_type op,
			input logic [IAD_XLEN-1:0] rb, input logic [IAD_IMM_W-1:0] imm);
		case (op)
			IAD_ADD, IAD_ADDC, IAD_ADDE: pick_b = rb;
			IAD_ADDME: pick_b = IAD_ALL_ONES;
			IAD_ADDIS: pick_b = {imm, {IAD_IMM_W{1'b0}}};
			IAD_ADDI, IAD_ADDIC, IAD_ADDIC_REC: pick_b = {{IAD_IMM_W{imm[IAD_IMM_W-1]}}, imm};
			default: pick_b = '0;
		endcase
	endfunction : pick_b

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic do_wr_w;
	logic exec_w;
	logic fx_wr_w;
	logic [IAD_XLEN:0] aw_word_w;
	logic [IAD_XLEN:0] ar_word_w;
	logic [IAD_XLEN-1:0] wr_word_w;
	logic [IAD_RIDX_W-1:0] wr_idx_w;

	// One write at a time: response must drain before the next is taken
	assign do_wr_w = st_reg.aw_have && st_reg.w_have && !st_reg.b_valid;
	assign aw_word_w = reg_word(st_reg, st_reg.aw_addr);
	assign ar_word_w = reg_word(st_reg, s_axi_araddr_in);
	assign wr_word_w = merge(aw_word_w[IAD_XLEN-1:0], st_reg.w_data, st_reg.w_strb);
	assign wr_idx_w = st_reg.aw_addr[IAD_IDX_LSB +: IAD_RIDX_W];
	assign exec_w = do_wr_w && st_reg.aw_addr == IAD_OFF_INSTR;
	assign fx_wr_w = do_wr_w && st_reg.aw_addr == IAD_OFF_FXEXC;

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	iad_op_type op_w;
	logic [IAD_RIDX_W-1:0] rd_w;
	logic [IAD_RIDX_W-1:0] ra_w;
	logic [IAD_RIDX_W-1:0] rb_w;
	logic [IAD_IMM_W-1:0] imm_w;
	logic [IAD_XLEN-1:0] gpr_a_w;
	logic [IAD_XLEN-1:0] gpr_b_w;
	logic zero_sel_w;
	logic [IAD_XLEN-1:0] opa_w;
	logic [IAD_XLEN-1:0] opb_w;
	logic cin_w;
	logic [IAD_XLEN-1:0] sum_w;
	logic cout_w;
	logic ovf_w;
	logic xo_form_w;
	logic ca_upd_w;
	logic ov_upd_w;
	logic cr_upd_w;
	logic so_new_w;

	assign op_w = decode_op(wr_word_w);
	assign rd_w = wr_word_w[IAD_RD_LSB +: IAD_RIDX_W];
	assign ra_w = wr_word_w[IAD_RA_LSB +: IAD_RIDX_W];
	assign rb_w = wr_word_w[IAD_RB_LSB +: IAD_RIDX_W];
	assign imm_w = wr_word_w[IAD_IMM_W-1:0];
	assign gpr_a_w = st_reg.gpr[ra_w];
	assign gpr_b_w = st_reg.gpr[rb_w];
	assign zero_sel_w = (op_w == IAD_ADDI || op_w == IAD_ADDIS) && ra_w == '0;
	assign opa_w = zero_sel_w ? '0 : gpr_a_w;
	assign opb_w = pick_b(op_w, gpr_b_w, imm_w);
	assign cin_w = (op_w == IAD_ADDE || op_w == IAD_ADDME || op_w == IAD_ADDZE) &&
		st_reg.ca;
	assign xo_form_w = op_w inside {IAD_ADD, IAD_ADDC, IAD_ADDE, IAD_ADDME, IAD_ADDZE};
	assign ca_upd_w = op_w inside {IAD_ADDC, IAD_ADDE, IAD_ADDME, IAD_ADDZE, IAD_ADDIC,
		IAD_ADDIC_REC};
	assign ov_upd_w = xo_form_w && wr_word_w[IAD_OE_BIT];
	assign cr_upd_w = (xo_form_w && wr_word_w[IAD_RC_BIT]) || op_w == IAD_ADDIC_REC;
	assign so_new_w = st_reg.so || (ov_upd_w && ovf_w);

	iad_adder u_adder (
		.a_in(opa_w),
		.b_in(opb_w),
		.carry_in(cin_w),
		.sum_out(sum_w),
		.carry_out(cout_w),
		.ovf_out(ovf_w)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		if (s_axi_awvalid_in && st_reg.aw_rdy) begin
			st_next.aw_have = 1'b1;
			st_next.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && st_reg.w_rdy) begin
			st_next.w_have = 1'b1;
			st_next.w_data = s_axi_wdata_in;
			st_next.w_strb = s_axi_wstrb_in;
		end
		if (st_reg.b_valid && s_axi_bready_in) begin
			st_next.b_valid = 1'b0;
		end
		if (do_wr_w) begin
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.b_valid = 1'b1;
			st_next.b_resp = aw_word_w[IAD_XLEN] ? IAD_RESP_OKAY : IAD_RESP_SLVERR;
			if (exec_w) begin
				st_next.last_instr = wr_word_w;
				st_next.last_ok = op_w != IAD_NONE;
				st_next.last_bad = op_w == IAD_NONE;
				// Unknown words leave every architected register alone
				if (op_w != IAD_NONE) begin
					st_next.gpr[rd_w] = sum_w;
					if (ca_upd_w) begin
						st_next.ca = cout_w;
					end
					if (ov_upd_w) begin
						st_next.ov = ovf_w;
						st_next.so = so_new_w;
					end
					// Flags come from the wrapped sum, not the exact one
					if (cr_upd_w) begin
						st_next.cr0[IAD_CR_NEG] = sum_w[IAD_XLEN-1];
						st_next.cr0[IAD_CR_POS] = !sum_w[IAD_XLEN-1] && |sum_w;
						st_next.cr0[IAD_CR_ZERO] = ~|sum_w;
						st_next.cr0[IAD_CR_SO] = so_new_w;
					end
				end
			end else if (fx_wr_w) begin
				st_next.ca = wr_word_w[IAD_FX_UWRAP];
				st_next.ov = wr_word_w[IAD_FX_SWRAP];
				st_next.so = wr_word_w[IAD_FX_STICKY];
			end else if (st_reg.aw_addr == IAD_OFF_CFZ) begin
				st_next.cr0 = wr_word_w[3:0];
			end else if ((st_reg.aw_addr & IAD_WIN_MASK) == IAD_OFF_GPR) begin
				st_next.gpr[wr_idx_w] = wr_word_w;
			end else if ((st_reg.aw_addr & IAD_WIN_MASK) == IAD_OFF_FPR && !wr_idx_w[4]) begin
				// Two bus words per 64-bit float register
				if (wr_idx_w[0]) begin
					st_next.float_register[wr_idx_w[3:1]][IAD_FLEN-1:IAD_XLEN] = wr_word_w;
				end else begin
					st_next.float_register[wr_idx_w[3:1]][IAD_XLEN-1:0] = wr_word_w;
				end
			end
		end
		if (st_reg.r_valid && s_axi_rready_in) begin
			st_next.r_valid = 1'b0;
		end
		if (s_axi_arvalid_in && st_reg.ar_rdy) begin
			st_next.r_valid = 1'b1;
			st_next.r_data = ar_word_w[IAD_XLEN-1:0];
			st_next.r_resp = ar_word_w[IAD_XLEN] ? IAD_RESP_OKAY : IAD_RESP_SLVERR;
		end
		st_next.aw_rdy = !st_next.aw_have && !st_next.b_valid;
		st_next.w_rdy = !st_next.w_have && !st_next.b_valid;
		st_next.ar_rdy = !st_next.r_valid;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!resetn_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign s_axi_awready_out = st_reg.aw_rdy;
	assign s_axi_wready_out = st_reg.w_rdy;
	assign s_axi_bvalid_out = st_reg.b_valid;
	assign s_axi_bresp_out = st_reg.b_resp;
	assign s_axi_arready_out = st_reg.ar_rdy;
	assign s_axi_rvalid_out = st_reg.r_valid;
	assign s_axi_rdata_out = st_reg.r_data;
	assign s_axi_rresp_out = st_reg.r_resp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [IAD_XLEN:0] chk_ab;
	logic [IAD_XLEN-1:0] chk_sum;
	logic chk_cout;
	logic [IAD_XLEN-1:0] chk_e;
	logic [IAD_XLEN-1:0] chk_me;
	logic [IAD_XLEN-1:0] chk_imm;

	assign chk_ab = {1'b0, gpr_a_w} + {1'b0, gpr_b_w};
	assign chk_sum = chk_ab[IAD_XLEN-1:0];
	assign chk_cout = chk_ab[IAD_XLEN];
	assign chk_e = chk_sum + {{(IAD_XLEN-1){1'b0}}, st_reg.ca};
	assign chk_me = gpr_a_w + {{(IAD_XLEN-1){1'b0}}, st_reg.ca} - 32'h0000_0001;
	assign chk_imm = (op_w == IAD_ADDIS) ? {imm_w, 16'h0000} :
		{{16{imm_w[IAD_IMM_W-1]}}, imm_w};

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	sequence s_exec_op(iad_op_type o);
		exec_w && op_w == o;
	endsequence

	a_add_plain: assert property (s_exec_op(IAD_ADD) |=>
		st_reg.gpr[$past(rd_w)] == $past(chk_sum) && st_reg.ca == $past(st_reg.ca))
		else $error("add result or carry wrong");
	a_addc_carry: assert property (s_exec_op(IAD_ADDC) |=>
		st_reg.ca == $past(chk_cout) && st_reg.gpr[$past(rd_w)] == $past(chk_sum))
		else $error("add carrying result or carry wrong");
	a_adde_sum: assert property (s_exec_op(IAD_ADDE) |=>
		st_reg.gpr[$past(rd_w)] == $past(chk_e))
		else $error("add extended result wrong");
	a_imm_quiet: assert property ((s_exec_op(IAD_ADDI) or s_exec_op(IAD_ADDIS)) |=>
		$stable(st_reg.cr0) && $stable(st_reg.ca) && $stable(st_reg.so) && $stable(st_reg.ov))
		else $error("immediate add altered status");
	a_zero_src_sel: assert property ((s_exec_op(IAD_ADDI) or s_exec_op(IAD_ADDIS)) ##0
		ra_w == '0 |=> st_reg.gpr[$past(rd_w)] == $past(chk_imm))
		else $error("zero source field did not select zero");
	a_addic_cr_keep: assert property (s_exec_op(IAD_ADDIC) |=> $stable(st_reg.cr0))
		else $error("add immediate carrying altered condition field");
	a_rec_flags: assert property (exec_w && cr_upd_w |=>
		st_reg.cr0[IAD_CR_ZERO] == (st_reg.gpr[$past(rd_w)] == '0) &&
		st_reg.cr0[IAD_CR_NEG] == st_reg.gpr[$past(rd_w)][IAD_XLEN-1] &&
		st_reg.cr0[IAD_CR_SO] == st_reg.so)
		else $error("condition field disagrees with result");
	a_addme_sum: assert property (s_exec_op(IAD_ADDME) |=>
		st_reg.gpr[$past(rd_w)] == $past(chk_me))
		else $error("add to minus one result wrong");
	a_ov_hold: assert property (exec_w && !ov_upd_w |=> $stable(st_reg.ov))
		else $error("signed wrap changed without overflow enable");
	a_so_sticky: assert property ($fell(st_reg.so) |-> $past(fx_wr_w))
		else $error("sticky signed wrap cleared by an add");
endmodule : iad_add_datapath

// file: tb/test_iad_add_datapath.sv
// Register-bus bench of the integer add datapath
`timescale 1ns/1ps
module test_iad_add_datapath;
	import iad_pkg::*;
	logic clk_sys_in;
	logic resetn_in;
	logic aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
	logic ar_valid, ar_ready, r_valid, r_ready;
	logic [11:0] aw_addr, ar_addr;
	logic [31:0] w_data, r_data, rd_word;
	logic [3:0] w_strb;
	logic [1:0] b_resp, r_resp, rd_resp;
	int n_mismatch;
	int comparisons;

	iad_add_datapath dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
		.s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready), .s_axi_awaddr_in(aw_addr),
		.s_axi_wvalid_in(w_valid), .s_axi_wready_out(w_ready), .s_axi_wdata_in(w_data),
		.s_axi_wstrb_in(w_strb), .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
		.s_axi_bresp_out(b_resp), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(ar_ready),
		.s_axi_araddr_in(ar_addr), .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready),
		.s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp));

	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_resp

	task automatic axi_write(input logic [11:0] addr, input logic [31:0] data,
			input logic [3:0] strb, input logic [1:0] exp_resp);
		int n;
		@(posedge clk_sys_in);
		aw_valid <= 1'h1;
		aw_addr <= addr;
		w_valid <= 1'h1;
		w_data <= data;
		w_strb <= strb;
		b_ready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (aw_valid && aw_ready) aw_valid <= 1'h0;
			if (w_valid && w_ready) w_valid <= 1'h0;
		end while (b_valid !== 1'h1 && n < 100);
		// Handshake arrival counts as a result so a hang is reported
		check_word({31'h0, b_valid}, 32'h1);
		check_resp(b_resp, exp_resp);
		b_ready <= 1'h0;
	endtask : axi_write

	task automatic axi_read(input logic [11:0] addr);
		int n;
		@(posedge clk_sys_in);
		ar_valid <= 1'h1;
		ar_addr <= addr;
		r_ready <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
			if (ar_valid && ar_ready) ar_valid <= 1'h0;
		end while (r_valid !== 1'h1 && n < 100);
		check_word({31'h0, r_valid}, 32'h1);
		rd_word = r_data;
		rd_resp = r_resp;
		r_ready <= 1'h0;
	endtask : axi_read

	task automatic expect_reg(input logic [11:0] addr, input logic [31:0] exp);
		axi_read(addr);
		check_resp(rd_resp, IAD_RESP_OKAY);
		check_word(rd_word, exp);
	endtask : expect_reg

	task automatic put(input logic [11:0] addr, input logic [31:0] data);
		axi_write(addr, data, 4'hf, IAD_RESP_OKAY);
	endtask : put

	function automatic logic [11:0] gpr(input logic [4:0] n);
		return IAD_OFF_GPR | {5'h0, n, 2'h0};
	endfunction : gpr

	function automatic logic [31:0] xo_form(input logic [4:0] rd, input logic [4:0] ra,
			input logic [4:0] rb, input logic oe, input logic [8:0] xo, input logic rc);
		return {IAD_OP_XO, rd, ra, rb, oe, xo, rc};
	endfunction : xo_form

	function automatic logic [31:0] d_form(input logic [5:0] op, input logic [4:0] rd,
			input logic [4:0] ra, input logic [15:0] imm);
		return {op, rd, ra, imm};
	endfunction : d_form

	task automatic finish_test();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// A full run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_mismatch++;
		$display("wrong value at %0t: got %h expected %h", $time, 1'h0, 1'h1);
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n_mismatch = 0;
		comparisons = 0;
		resetn_in = 1'h0;
		{aw_valid, w_valid, b_ready, ar_valid, r_ready} = 5'h0;
		aw_addr = 12'h0;
		ar_addr = 12'h0;
		w_data = 32'h0;
		w_strb = 4'h0;
		repeat (16) @(posedge clk_sys_in);
		resetn_in <= 1'h1;
		expect_reg(IAD_OFF_FXEXC, 32'h0);
		expect_reg(IAD_OFF_CFZ, 32'h0);
		// Signed overflow with record and overflow enable, carry held
		put(gpr(5'h1), 32'h7fff_ffff);
		put(gpr(5'h2), 32'h0000_0001);
		put(IAD_OFF_FXEXC, 32'h1);
		put(IAD_OFF_INSTR, xo_form(5'h3, 5'h1, 5'h2, 1'h1, IAD_XO_ADD, 1'h1));
		expect_reg(gpr(5'h3), 32'h8000_0000);
		expect_reg(IAD_OFF_FXEXC, 32'h7);
		expect_reg(IAD_OFF_CFZ, 32'h9);
		put(IAD_OFF_INSTR, xo_form(5'h4, 5'h2, 5'h2, 1'h1, IAD_XO_ADD, 1'h0));
		expect_reg(gpr(5'h4), 32'h2);
		expect_reg(IAD_OFF_FXEXC, 32'h5);
		expect_reg(IAD_OFF_CFZ, 32'h9);
		// Carrying forms
		put(IAD_OFF_FXEXC, 32'h0);
		put(gpr(5'h1), 32'hffff_ffff);
		put(IAD_OFF_INSTR, xo_form(5'h3, 5'h1, 5'h2, 1'h0, IAD_XO_ADDC, 1'h1));
		expect_reg(gpr(5'h3), 32'h0);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		expect_reg(IAD_OFF_CFZ, 32'h2);
		put(gpr(5'h5), 32'h5);
		put(gpr(5'h6), 32'h6);
		put(IAD_OFF_INSTR, xo_form(5'h7, 5'h5, 5'h6, 1'h0, IAD_XO_ADDE, 1'h1));
		expect_reg(gpr(5'h7), 32'hc);
		expect_reg(IAD_OFF_FXEXC, 32'h0);
		expect_reg(IAD_OFF_CFZ, 32'h4);
		put(IAD_OFF_INSTR, xo_form(5'h8, 5'h5, 5'h0, 1'h1, IAD_XO_ADDME, 1'h0));
		expect_reg(gpr(5'h8), 32'h4);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		put(IAD_OFF_INSTR, xo_form(5'h9, 5'h1, 5'h0, 1'h0, IAD_XO_ADDZE, 1'h0));
		expect_reg(gpr(5'h9), 32'h0);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		put(IAD_OFF_INSTR, xo_form(5'h9, 5'h5, 5'h0, 1'h0, IAD_XO_ADDZE, 1'h0));
		expect_reg(gpr(5'h9), 32'h6);
		expect_reg(IAD_OFF_FXEXC, 32'h0);
		// Add immediate and shifted leave status alone, carrying forms do not; register zero field means constant
		put(IAD_OFF_FXEXC, 32'h1);
		put(IAD_OFF_CFZ, 32'h8);
		put(gpr(5'h0), 32'h100);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDI, 5'ha, 5'h5, 16'hfffd));
		expect_reg(gpr(5'ha), 32'h2);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDI, 5'hb, 5'h0, 16'h1234));
		expect_reg(gpr(5'hb), 32'h1234);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDIS, 5'hc, 5'h5, 16'h8001));
		expect_reg(gpr(5'hc), 32'h8001_0005);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDIS, 5'hd, 5'h0, 16'h8001));
		expect_reg(gpr(5'hd), 32'h8001_0000);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		expect_reg(IAD_OFF_CFZ, 32'h8);
		put(IAD_OFF_FXEXC, 32'h0);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDIC, 5'he, 5'h1, 16'h0001));
		expect_reg(gpr(5'he), 32'h0);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		expect_reg(IAD_OFF_CFZ, 32'h8);
		put(IAD_OFF_INSTR, d_form(IAD_OP_ADDIC_REC, 5'hf, 5'h5, 16'hfffb));
		expect_reg(gpr(5'hf), 32'h0);
		expect_reg(IAD_OFF_FXEXC, 32'h1);
		expect_reg(IAD_OFF_CFZ, 32'h2);
		// Float register as two words
		put(IAD_OFF_FPR | 12'h008, 32'h89ab_cdef);
		put(IAD_OFF_FPR | 12'h00c, 32'h0123_4567);
		expect_reg(IAD_OFF_FPR | 12'h008, 32'h89ab_cdef);
		expect_reg(IAD_OFF_FPR | 12'h00c, 32'h0123_4567);
		// Unmapped place, unknown word and read-only status
		axi_write(12'h010, 32'h5a5a_5a5a, 4'hf, IAD_RESP_SLVERR);
		axi_read(12'h010);
		check_resp(rd_resp, IAD_RESP_SLVERR);
		check_word(rd_word, 32'h0);
		put(IAD_OFF_INSTR, 32'h0);
		put(IAD_OFF_STAT, 32'h0);
		expect_reg(IAD_OFF_STAT, 32'h2);
		expect_reg(gpr(5'h1), 32'hffff_ffff);
		finish_test();
	end
endmodule : test_iad_add_datapath
